/* File: inc/dcw_defs.svh */
// dcw_defs.svh: register offsets, control bit positions, reset values and cache geometry
// for the data cache / write buffer block; included by bare name.
`ifndef DCW_DEFS_SVH
`define DCW_DEFS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define DCW_CTRL_OFS 8'h00
`define DCW_LOCK_OFS 8'h04
`define DCW_STAT_OFS 8'h08

// ****************************************
// control and status fields
// ****************************************
`define DCW_CTRL_MMU_BIT 0
`define DCW_CTRL_CACHE_BIT 2
`define DCW_CTRL_RR_BIT 14
`define DCW_STAT_EMPTY_BIT 0
`define DCW_STAT_BUSY_BIT 1
`define DCW_STAT_WBD_LO 8
`define DCW_STAT_WBA_LO 16
`define DCW_LFSR_SEED 7'h5b

// ****************************************
// geometry
// ****************************************
`define DCW_TAG_VA_LO 27
`define DCW_TAG_W 51
`define DCW_LINES 512
`define DCW_WORDS 4096
`define DCW_LINE_WORDS 8
`define DCW_HALF_WORDS 4
`define DCW_WB_WORDS 16
`define DCW_WB_ADDRS 4

`endif

/* File: inc/dcw_pkg.sv */
// dcw_pkg: types shared by the data cache / write buffer design.
// assumes nothing beyond a SystemVerilog compiler.
package dcw_pkg;

  typedef enum logic [3:0] {
    S_IDLE, S_TAG, S_CMP, S_DECIDE, S_HITRET, S_EVICT, S_FILL, S_BUS, S_PUSH
  } dcw_state_e;

  // one buffered data word and its byte lanes
  typedef struct packed {
    logic [3:0] be;
    logic [31:0] data;
  } dcw_wbd_s;

  // one buffered address: word address and run length in words
  typedef struct packed {
    logic [29:0] addr;
    logic [3:0] len;
  } dcw_wba_s;

endpackage

/* File: hw/dcw_ram.sv */
// dcw_ram: single-port-write, single-port-read memory with lane write enables.
// assumes one clock; read data appear one edge after a read enable and then hold.
`timescale 1ns/1ns
`default_nettype none
module dcw_ram #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4096,
  parameter int LANES = 4,
  localparam int AW = $clog2(DEPTH),
  localparam int LW = WIDTH / LANES
) (
  input wire logic sys_clk,
  input wire logic we,
  input wire logic [LANES-1:0] wlane,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  if (WIDTH % LANES != 0) begin : g_bad_lanes
    $error("dcw_ram: WIDTH must divide into LANES");
  end

  always_ff @(posedge sys_clk) begin
    if (re) begin
      rdata <= mem[raddr];
    end
    for (int i = 0; i < LANES; i++) begin
      if (we && wlane[i]) begin
        mem[waddr][i*LW +: LW] <= wdata[i*LW +: LW];
      end
    end
  end
endmodule
`default_nettype wire

/* File: hw/dcw_top.sv */
// dcw_top: data cache and write buffer between the core load/store port and the system bus.
// assumes core, bus memory side and AHB-Lite master all run on sys_clk.
`timescale 1ns/1ns
`default_nettype none
`include "dcw_defs.svh"
module dcw_top #(
  parameter int WB_WORDS = `DCW_WB_WORDS,
  parameter int WB_ADDRS = `DCW_WB_ADDRS
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic mmu_enable,
  input wire logic core_req,
  input wire logic core_write,
  input wire logic core_swap,
  input wire logic core_burst,
  input wire logic [3:0] core_be,
  input wire logic [31:0] core_vaddr,
  input wire logic [31:0] core_paddr,
  input wire logic [31:0] core_wdata,
  input wire logic core_ctt,
  input wire logic core_btt,
  input wire logic core_mmu_abort,
  output logic core_ack,
  output logic core_abort,
  output logic [31:0] core_rdata,
  output logic bus_valid,
  output logic [31:0] bus_addr,
  output logic bus_write,
  output logic [31:0] bus_wdata,
  output logic [3:0] bus_be,
  output logic bus_seq,
  output logic bus_lock_out,
  input wire logic bus_ready,
  input wire logic [31:0] bus_rdata,
  input wire logic bus_error
);
  import dcw_pkg::*;

  localparam int DW = $clog2(WB_WORDS);
  localparam int AW = $clog2(WB_ADDRS);
  localparam logic [DW:0] WBD_MAX = (DW+1)'(WB_WORDS);
  localparam logic [AW:0] WBA_MAX = (AW+1)'(WB_ADDRS);

  // ****************************************
  // parameter checks
  // ****************************************
  // an eviction must fit whole into an empty buffer; wrap-around pointers need powers of two
  if (WB_WORDS < `DCW_LINE_WORDS || (WB_WORDS & (WB_WORDS - 1)) != 0 || WB_ADDRS < 2 ||
      (WB_ADDRS & (WB_ADDRS - 1)) != 0) begin : g_bad_wb
    $error("dcw_top: write buffer sizes unsupported");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    dcw_state_e st;
    logic ctl_mmu;
    logic ctl_cache;
    logic ctl_rr;
    logic [5:0] lock_base;
    logic [6:0] lfsr;
    logic [5:0] rr_ctr;
    logic [5:0] scan_idx;
    logic [5:0] hit_way;
    logic [5:0] victim;
    logic hit;
    logic sw_wr;
    logic fill_err;
    logic [3:0] word_cnt;
    logic [31:0] vaddr;
    logic [31:0] paddr;
    logic [31:0] wdata;
    logic [31:0] rdata_hold;
    logic [3:0] be;
    logic write;
    logic swap;
    logic burst;
    logic ctt;
    logic btt;
    logic [`DCW_LINES-1:0] valid;
    logic [2*`DCW_LINES-1:0] dirty;
    logic core_ack;
    logic core_abort;
    logic [31:0] core_rdata;
    logic bus_valid;
    logic bus_own;
    logic bus_write;
    logic bus_seq;
    logic bus_lock;
    logic [31:0] bus_addr;
    logic [31:0] bus_wdata;
    logic [3:0] bus_be;
    dcw_wbd_s [WB_WORDS-1:0] wbd;
    logic [DW-1:0] wbd_head;
    logic [DW-1:0] wbd_tail;
    logic [DW:0] wbd_cnt;
    dcw_wba_s [WB_ADDRS-1:0] wba;
    logic [AW-1:0] wba_head;
    logic [AW-1:0] wba_tail;
    logic [AW:0] wba_cnt;
    logic [3:0] wb_idx;
    logic ahb_rd;
    logic ahb_wr;
    logic [7:0] ahb_ofs;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
  } dcw_regs_s;

  dcw_regs_s r;
  dcw_regs_s n;

  logic tag_re;
  logic [8:0] tag_raddr;
  logic tag_we;
  logic [`DCW_TAG_W-1:0] tag_wdata;
  logic [`DCW_TAG_W-1:0] tag_rdata;
  logic data_re;
  logic [11:0] data_raddr;
  logic data_we;
  logic [3:0] data_be;
  logic [11:0] data_waddr;
  logic [31:0] data_wdata;
  logic [31:0] data_rdata;

  function automatic dcw_regs_s do_ack(dcw_regs_s s, logic [31:0] d, logic err);
    s.core_ack = 1'b1;
    s.core_rdata = d;
    s.core_abort = err;
    s.bus_lock = 1'b0;
    s.st = S_IDLE;
    return s;
  endfunction

  // a swap carries on to its store half without answering the core in between
  function automatic dcw_regs_s fin_rd(dcw_regs_s s, logic [31:0] d, logic err);
    if (s.swap && !err) begin
      s.sw_wr = 1'b1;
      s.rdata_hold = d;
      s.st = S_DECIDE;
    end else begin
      s = do_ack(s, d, err);
    end
    return s;
  endfunction

  // ****************************************
  // tag and data stores
  // ****************************************
  // tag word holds virtual tag [31:8] above the physical line address
  dcw_ram #(.WIDTH(`DCW_TAG_W), .DEPTH(`DCW_LINES), .LANES(1)) u_tag (
    .sys_clk(sys_clk), .we(tag_we), .wlane(1'b1), .waddr(tag_raddr), .wdata(tag_wdata),
    .re(tag_re), .raddr(tag_raddr), .rdata(tag_rdata));

  dcw_ram #(.WIDTH(32), .DEPTH(`DCW_WORDS), .LANES(4)) u_data (
    .sys_clk(sys_clk), .we(data_we), .wlane(data_be), .waddr(data_waddr), .wdata(data_wdata),
    .re(data_re), .raddr(data_raddr), .rdata(data_rdata));

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    logic [2:0] seg;
    logic [2:0] word;
    logic cached;
    logic use_hit;
    logic wr;
    logic bus_done;
    logic [5:0] pick;
    logic [5:0] vic;
    logic d0;
    logic d1;
    logic [3:0] ev_n;
    logic [2:0] ev_start;
    logic [29:0] wa;
    logic [31:0] rd_val;
    seg = r.vaddr[7:5];
    word = r.vaddr[4:2];
    cached = r.ctt && r.ctl_cache;
    use_hit = r.hit && cached;
    wr = r.write || r.sw_wr;
    bus_done = r.bus_valid && bus_ready;
    pick = r.ctl_rr ? r.rr_ctr : r.lfsr[5:0];
    vic = (pick < r.lock_base) ? r.lock_base : pick;
    d0 = r.dirty[{seg, r.victim, 1'b0}];
    d1 = r.dirty[{seg, r.victim, 1'b1}];
    ev_n = (d0 && d1) ? 4'h8 : 4'h4;
    ev_start = d0 ? 3'h0 : 3'h4;
    wa = r.wba[r.wba_head].addr + 30'(r.wb_idx);
    n = r;
    n.core_ack = 1'b0;
    n.core_abort = 1'b0;
    n.hresp = 1'b0;
    n.lfsr = {r.lfsr[5:0], r.lfsr[6] ^ r.lfsr[5]};
    tag_re = 1'b0;
    tag_raddr = {seg, r.scan_idx};
    tag_we = 1'b0;
    tag_wdata = {r.vaddr[31:8], r.paddr[31:5]};
    data_re = 1'b0;
    data_raddr = {seg, r.hit_way, word};
    data_we = 1'b0;
    data_be = 4'hf;
    data_waddr = {seg, r.victim, r.word_cnt[2:0]};
    data_wdata = bus_rdata;

    // ****************************************
    // register slave
    // ****************************************
    case (r.ahb_ofs)
      `DCW_CTRL_OFS: rd_val = (32'(r.ctl_mmu) << `DCW_CTRL_MMU_BIT) |
                              (32'(r.ctl_cache) << `DCW_CTRL_CACHE_BIT) |
                              (32'(r.ctl_rr) << `DCW_CTRL_RR_BIT);
      `DCW_LOCK_OFS: rd_val = {26'h0, r.lock_base};
      `DCW_STAT_OFS: rd_val = 32'((32'(r.wba_cnt == '0) << `DCW_STAT_EMPTY_BIT) |
                                  (32'(r.st != S_IDLE) << `DCW_STAT_BUSY_BIT) |
                                  (32'(r.wbd_cnt) << `DCW_STAT_WBD_LO) |
                                  (32'(r.wba_cnt) << `DCW_STAT_WBA_LO));
      default: rd_val = 32'h0;
    endcase
    n.hreadyout = 1'b1;
    n.ahb_wr = 1'b0;
    n.ahb_rd = 1'b0;
    if (r.ahb_wr) begin
      case (r.ahb_ofs)
        `DCW_CTRL_OFS: begin
          n.ctl_mmu = hwdata[`DCW_CTRL_MMU_BIT];
          n.ctl_cache = hwdata[`DCW_CTRL_CACHE_BIT];
          n.ctl_rr = hwdata[`DCW_CTRL_RR_BIT];
        end
        `DCW_LOCK_OFS: n.lock_base = hwdata[5:0];
        default: ;
      endcase
    end
    if (r.ahb_rd) begin
      n.hrdata = rd_val;
    end
    if (hsel && htrans[1] && hready) begin
      n.ahb_ofs = haddr[7:0];
      n.ahb_wr = hwrite;
      n.ahb_rd = !hwrite;
      n.hreadyout = hwrite;  // one wait state lets a read see a write just before it
    end

    // ****************************************
    // write buffer drain
    // ****************************************
    if (bus_done) begin
      n.bus_valid = 1'b0;
    end
    if (bus_done && !r.bus_own) begin
      n.wbd_head = r.wbd_head + 1'b1;
      n.wbd_cnt = r.wbd_cnt - 1'b1;
      if (r.wb_idx == r.wba[r.wba_head].len - 4'h1) begin
        n.wba_head = r.wba_head + 1'b1;
        n.wba_cnt = r.wba_cnt - 1'b1;
        n.wb_idx = 4'h0;
      end else begin
        n.wb_idx = r.wb_idx + 4'h1;
      end
    end
    if (!r.bus_valid && r.wba_cnt != '0) begin
      n.bus_valid = 1'b1;
      n.bus_own = 1'b0;
      n.bus_write = 1'b1;
      n.bus_addr = {wa, 2'b00};
      n.bus_wdata = r.wbd[r.wbd_head].data;
      n.bus_be = r.wbd[r.wbd_head].be;
      n.bus_seq = (r.wb_idx != 4'h0) && (wa[7:0] != 8'h0);
    end

    // ****************************************
    // access sequencer
    // ****************************************
    case (r.st)
      S_IDLE: begin
        if (core_req) begin
          n.vaddr = core_vaddr;
          n.paddr = core_paddr;
          n.wdata = core_wdata;
          n.be = core_be;
          n.write = core_write && !core_swap;
          n.swap = core_swap;
          n.burst = core_burst;
          n.ctt = core_ctt;
          n.btt = core_btt;
          n.sw_wr = 1'b0;
          n.hit = 1'b0;
          n.scan_idx = 6'h0;
          n.rdata_hold = 32'h0;
          if (core_mmu_abort) begin
            n = do_ack(n, 32'h0, 1'b1);
          end else begin
            n.st = r.ctl_cache ? S_TAG : S_DECIDE;
          end
        end
      end
      S_TAG: begin
        tag_re = 1'b1;
        n.st = S_CMP;
      end
      S_CMP: begin
        if (r.valid[{seg, r.scan_idx}] &&
            tag_rdata[`DCW_TAG_W-1:`DCW_TAG_VA_LO] == r.vaddr[31:8]) begin
          n.hit = 1'b1;
          n.hit_way = r.scan_idx;
          n.st = S_DECIDE;
        end else if (r.scan_idx == 6'h3f) begin
          n.st = S_DECIDE;
        end else begin
          n.scan_idx = r.scan_idx + 6'h1;
          n.st = S_TAG;
        end
      end
      S_DECIDE: begin
        n.word_cnt = 4'h0;
        n.fill_err = 1'b0;
        if (!wr) begin
          if (use_hit) begin
            data_re = 1'b1;
            n.st = S_HITRET;
          end else if (cached) begin
            // victim drawn from the unlocked indices of this segment
            n.victim = vic;
            tag_re = 1'b1;
            tag_raddr = {seg, vic};
            n.valid[{seg, vic}] = 1'b0;
            n.st = (r.valid[{seg, vic}] && (r.dirty[{seg, vic, 1'b0}] ||
                    r.dirty[{seg, vic, 1'b1}])) ? S_EVICT : S_FILL;
          end else begin
            n.st = S_BUS;
          end
        end else if (!cached && (!r.btt || r.swap)) begin
          n.st = S_BUS;
        end else begin
          if (use_hit) begin
            data_we = 1'b1;
            data_be = r.be;
            data_waddr = {seg, r.hit_way, word};
            data_wdata = r.wdata;
          end
          if (use_hit && r.btt) begin
            n.dirty[{seg, r.hit_way, r.vaddr[4]}] = 1'b1;
            n = do_ack(n, r.rdata_hold, 1'b0);
          end else begin
            n.st = S_PUSH;
          end
        end
      end
      S_HITRET: begin
        n = fin_rd(n, data_rdata, 1'b0);
      end
      S_EVICT: begin
        // dirty data go into an empty buffer before the fill read starts
        if (r.word_cnt != 4'h0 || r.wba_cnt == '0) begin
          if (r.word_cnt < ev_n) begin
            data_re = 1'b1;
            data_raddr = {seg, r.victim, ev_start + r.word_cnt[2:0]};
          end
          if (r.word_cnt != 4'h0) begin
            n.wbd[r.wbd_tail] = '{be: 4'hf, data: data_rdata};
            n.wbd_tail = r.wbd_tail + 1'b1;
            n.wbd_cnt = n.wbd_cnt + 1'b1;
          end
          if (r.word_cnt == ev_n) begin
            n.wba[r.wba_tail] = '{addr: {tag_rdata[26:0], ev_start}, len: ev_n};
            n.wba_tail = r.wba_tail + 1'b1;
            n.wba_cnt = n.wba_cnt + 1'b1;
            n.dirty[{seg, r.victim, 1'b0}] = 1'b0;
            n.dirty[{seg, r.victim, 1'b1}] = 1'b0;
            n.word_cnt = 4'h0;
            n.st = S_FILL;
          end else begin
            n.word_cnt = r.word_cnt + 4'h1;
          end
        end
      end
      S_FILL: begin
        if (!r.bus_valid && r.wba_cnt == '0) begin
          n.bus_valid = 1'b1;
          n.bus_own = 1'b1;
          n.bus_write = 1'b0;
          n.bus_addr = {r.paddr[31:5], r.word_cnt[2:0], 2'b00};
          n.bus_be = 4'hf;
          n.bus_seq = r.word_cnt != 4'h0;
        end
        if (bus_done && r.bus_own) begin
          data_we = 1'b1;
          n.fill_err = r.fill_err || bus_error;
          if (r.word_cnt[2:0] == word) begin
            n.rdata_hold = bus_rdata;
          end
          if (r.word_cnt == 4'h7) begin
            tag_we = 1'b1;
            tag_raddr = {seg, r.victim};
            n.valid[{seg, r.victim}] = !n.fill_err;
            n.rr_ctr = (r.victim == 6'h3f) ? r.lock_base : r.victim + 6'h1;
            n.hit = 1'b1;
            n.hit_way = r.victim;
            n = fin_rd(n, n.rdata_hold, n.fill_err);
          end else begin
            n.word_cnt = r.word_cnt + 4'h1;
          end
        end
      end
      S_BUS: begin
        if (!r.bus_valid && r.wba_cnt == '0) begin
          n.bus_valid = 1'b1;
          n.bus_own = 1'b1;
          n.bus_write = wr;
          n.bus_addr = r.paddr;
          n.bus_wdata = r.wdata;
          n.bus_be = r.be;
          // multiples run on sequentially only while the cache is enabled, never past a 1KB edge
          n.bus_seq = r.burst && r.ctl_cache && (r.paddr[9:2] != 8'h0);
          n.bus_lock = r.swap;
        end
        if (bus_done && r.bus_own) begin
          if (wr) begin
            n = do_ack(n, r.rdata_hold, bus_error);
          end else begin
            n = fin_rd(n, bus_rdata, bus_error);
          end
        end
      end
      S_PUSH: begin
        if (r.wbd_cnt < WBD_MAX && r.wba_cnt < WBA_MAX) begin
          n.wbd[r.wbd_tail] = '{be: r.be, data: r.wdata};
          n.wbd_tail = r.wbd_tail + 1'b1;
          n.wbd_cnt = n.wbd_cnt + 1'b1;
          n.wba[r.wba_tail] = '{addr: r.paddr[31:2], len: 4'h1};
          n.wba_tail = r.wba_tail + 1'b1;
          n.wba_cnt = n.wba_cnt + 1'b1;
          n = do_ack(n, r.rdata_hold, 1'b0);
        end
      end
      default: n.st = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      r <= '0;
      r.st <= S_IDLE;
      r.lfsr <= `DCW_LFSR_SEED;
      r.hreadyout <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign hreadyout = r.hreadyout;
  assign hrdata = r.hrdata;
  assign hresp = r.hresp;
  assign mmu_enable = r.ctl_mmu;
  assign core_ack = r.core_ack;
  assign core_abort = r.core_abort;
  assign core_rdata = r.core_rdata;
  assign bus_valid = r.bus_valid;
  assign bus_addr = r.bus_addr;
  assign bus_write = r.bus_write;
  assign bus_wdata = r.bus_wdata;
  assign bus_be = r.bus_be;
  assign bus_seq = r.bus_seq;
  assign bus_lock_out = r.bus_lock;
endmodule
`default_nettype wire

/* File: verification/dcw_mem_model.sv */
// dcw_mem_model: bus-side memory for dcw_top; content derives from the address.
// assumes one sys_clk; writes are counted, not stored.
`timescale 1ns/1ns
`default_nettype none
module dcw_mem_model (
  input wire logic sys_clk,
  input wire logic bus_valid,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_write,
  input wire logic bus_seq,
  input wire logic bus_lock_out,
  input wire logic [4:0] slow,
  input wire logic err_on,
  output logic bus_ready,
  output logic [31:0] bus_rdata,
  output logic bus_error
);
  // ****
  // answer
  // ****
  logic [4:0] wait_cnt = 5'h0;
  logic [31:0] last_wa = 32'h0;
  logic [31:0] last_wd = 32'h0;
  logic last_seq = 1'b0;
  int n_rd = 0;
  int n_wr = 0;
  int n_lock = 0;
  assign bus_ready = bus_valid && wait_cnt >= slow;
  // no answer on the lines: show the inverse so a stale sample is caught
  assign bus_rdata = (bus_addr ^ 32'hffff0000) ^ {32{!bus_ready}};
  assign bus_error = bus_ready && err_on;
  always @(posedge sys_clk) begin
    wait_cnt <= (bus_valid && !bus_ready) ? wait_cnt + 5'h1 : 5'h0;
    if (bus_ready) begin
      last_seq <= bus_seq;
      if (bus_lock_out)
        n_lock <= n_lock + 1;
      if (bus_write) begin
        n_wr <= n_wr + 1;
        last_wa <= bus_addr;
        last_wd <= bus_wdata;
      end else
        n_rd <= n_rd + 1;
    end
  end
endmodule
`default_nettype wire

/* File: verification/dcw_top_asserts.sv */
// dcw_top_asserts: port-level properties of dcw_top.
// assumes the single sys_clk domain and synchronous rst_n.
`timescale 1ns/1ns
`default_nettype none
module dcw_top_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic mmu_enable,
  input wire logic core_req,
  input wire logic core_mmu_abort,
  input wire logic core_ack,
  input wire logic core_abort,
  input wire logic bus_valid,
  input wire logic [31:0] bus_addr,
  input wire logic bus_write,
  input wire logic bus_seq,
  input wire logic bus_lock_out,
  input wire logic bus_ready,
  input wire logic bus_error
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  wire go = hsel && htrans[1] && hready;
  AST_RST_QUIET: assert property (!$past(rst_n) |-> !bus_valid && !core_ack && hreadyout)
    else $error("active after reset");
  AST_ABORT_FAST: assert property (core_req && core_mmu_abort |-> ##[1:2] core_abort)
    else $error("abort late");
  AST_BUS_HOLD: assert property (bus_valid && !bus_ready |=> bus_valid && $stable(bus_addr))
    else $error("bus request moved");
  AST_BUS_SPLIT: assert property (bus_valid && bus_ready |=> !bus_valid)
    else $error("no idle between transfers");
  AST_NO_1KB_SEQ: assert property (bus_valid && bus_seq |-> bus_addr[9:0] != 10'h0)
    else $error("sequential at 1KB edge");
  AST_LOCK_ENDS: assert property (core_ack |=> !bus_lock_out)
    else $error("lock held");
  AST_LOCK_HELD: assert property (bus_lock_out && bus_valid && bus_ready && !bus_error
    && !bus_write |=> bus_lock_out) else $error("lock dropped inside swap");
  AST_CTRL_MMU: assert property (go && hwrite && haddr[7:0] == 8'h00 ##1 1'b1
    |=> mmu_enable == $past(hwdata[0])) else $error("mmu enable wrong");
  AST_READ_WAIT: assert property (go && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  CVR_LOCK: cover property (bus_valid && bus_lock_out && bus_write);
  CVR_SEQ: cover property (bus_valid && bus_seq && bus_ready);
  CVR_ABORT: cover property (core_ack && core_abort);
endmodule
bind dcw_top dcw_top_asserts chk_u (.*);
`default_nettype wire

/* File: verification/test_data_cache_write_buffer.sv */
// test_data_cache_write_buffer: self-checking bench for dcw_top.
// assumes dcw_mem_model on the bus side and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module test_data_cache_write_buffer;
  logic sys_clk, rst_n, hsel, hwrite, hreadyout, hresp, mmu_enable, err_on, ab;
  logic core_req, core_write, core_swap, core_burst, core_ctt, core_btt, core_mmu_abort;
  logic core_ack, core_abort, bus_valid, bus_write, bus_seq, bus_lock_out, bus_ready, bus_error;
  logic [31:0] haddr, hwdata, hrdata, core_vaddr, core_paddr, core_wdata, core_rdata;
  logic [31:0] bus_addr, bus_wdata, bus_rdata, rd;
  logic [1:0] htrans;
  logic [3:0] bus_be;
  logic [4:0] slow;
  int err_total, n_checks, r0, w0;
  int cyc = 0;
  localparam logic [31:0] MSK = 32'hffff0000;
  dcw_top dut_u (.hready(hreadyout), .hsize(3'h2), .core_be(4'hf), .*);
  dcw_mem_model mem_u (.*);
  // ****
  // clock, watchdog, tasks
  // ****
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // k = {xlate abort, burst, swap, write, ctt, btt}
  task automatic core(input logic [5:0] k, input logic [31:0] va, pa, wd);
    {core_mmu_abort, core_burst, core_swap, core_write, core_ctt, core_btt} <= k;
    core_vaddr <= va;
    core_paddr <= pa;
    core_wdata <= wd;
    core_req <= 1'b1;
    @(posedge sys_clk);
    core_req <= 1'b0;
    do @(posedge sys_clk); while (core_ack !== 1'b1);
    rd = core_rdata;
    ab = core_abort;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_regs();
    ahb(1'b0, 32'h0, 32'h0);
    chk("ctrl0", rd, 32'h0);
    chk("okay", hresp, 1'b0);
    ahb(1'b0, 32'h8, 32'h0);
    chk("empty", rd[0], 1'b1);
    ahb(1'b0, 32'hc, 32'h0);
    chk("unmap", rd, 32'h0);
    ahb(1'b1, 32'h0, 32'h4005);
    ahb(1'b0, 32'h0, 32'h0);
    chk("ctrl", rd, 32'h4005);
    chk("mmu1", mmu_enable, 1'b1);
    ahb(1'b1, 32'h0, 32'h0);
    @(posedge sys_clk);
    chk("mmu0", mmu_enable, 1'b0);
    $display("done regs");
  endtask
  task automatic t_unc();
    r0 = mem_u.n_rd;
    w0 = mem_u.n_wr;
    core(6'h00, 32'h100, 32'h100, 32'h0);
    chk("urd", rd, 32'h100 ^ MSK);
    core(6'h04, 32'h104, 32'h104, 32'h11);
    chk("uncached_unbuffered_region", mem_u.n_wr - w0, 1);
    core(6'h20, 32'h108, 32'h108, 32'h0);
    chk("xab", ab, 1'b1);
    chk("xbus", mem_u.n_rd - r0, 1);
    slow <= 5'h6;
    err_on <= 1'b1;
    core(6'h05, 32'h10c, 32'h10c, 32'h22);
    chk("ncbab", ab, 1'b0);
    chk("ncbq", mem_u.n_wr - w0, 1);
    core(6'h00, 32'h110, 32'h110, 32'h0);
    chk("rdab", ab, 1'b1);
    chk("drain", mem_u.n_wr - w0, 2);
    err_on <= 1'b0;
    w0 = mem_u.n_wr;
    slow <= 5'h14;
    for (int i = 0; i < 4; i++)
      core(6'h05, 32'h400 + i * 64, 32'h400 + i * 64, i);
    chk("four", mem_u.n_wr - w0, 0);
    core(6'h05, 32'h500, 32'h500, 32'h5);
    chk("stall", mem_u.n_wr > w0, 1'b1);
    core(6'h00, 32'h600, 32'h600, 32'h0);
    chk("order", mem_u.n_wr - w0, 5);
    slow <= 5'h0;
    $display("done uncached");
  endtask
  task automatic t_cache();
    ahb(1'b1, 32'h4, 32'h3f);
    ahb(1'b1, 32'h0, 32'h5);
    r0 = mem_u.n_rd;
    w0 = mem_u.n_wr;
    core(6'h02, 32'h2048, 32'h8048, 32'h0);
    chk("fill", rd, 32'h8048 ^ MSK);
    chk("flen", mem_u.n_rd - r0, 8);
    core(6'h02, 32'h2054, 32'h8054, 32'h0);
    chk("hit", rd, 32'h8054 ^ MSK);
    chk("hbus", mem_u.n_rd - r0, 8);
    core(6'h06, 32'h2054, 32'h8054, 32'h1234);
    core(6'h02, 32'h2054, 32'h8054, 32'h0);
    chk("wt", rd, 32'h1234);
    core(6'h07, 32'h2058, 32'h8058, 32'h5678);
    core(6'h03, 32'h2058, 32'h8058, 32'h0);
    chk("wb", rd, 32'h5678);
    core(6'h00, 32'h3000, 32'h9000, 32'h0);
    chk("ctt0", mem_u.n_rd - r0, 9);
    chk("wbnb", mem_u.n_wr - w0, 1);
    ahb(1'b1, 32'h0, 32'h1);
    core(6'h02, 32'h2058, 32'h8058, 32'h0);
    chk("off", rd, 32'h8058 ^ MSK);
    ahb(1'b1, 32'h0, 32'h5);
    core(6'h03, 32'h2058, 32'h8058, 32'h0);
    chk("kept", rd, 32'h5678);
    core(6'h0b, 32'h2058, 32'h8058, 32'h9abc);
    chk("csold", rd, 32'h5678);
    chk("cslk", mem_u.n_lock, 0);
    core(6'h03, 32'h2058, 32'h8058, 32'h0);
    chk("csnew", rd, 32'h9abc);
    w0 = mem_u.n_wr;
    core(6'h09, 32'h300, 32'h300, 32'h77);
    chk("usold", rd, 32'h300 ^ MSK);
    chk("uswr", mem_u.n_wr - w0, 1);
    chk("uslk", mem_u.n_lock, 2);
    chk("uswd", mem_u.last_wd, 32'h77);
    // only index 63 is unlocked, so this miss evicts the dirty line
    core(6'h03, 32'h4048, 32'ha048, 32'h0);
    chk("wblen", mem_u.n_wr - w0, 5);
    chk("wbadr", mem_u.last_wa, 32'h805c);
    chk("wbdat", mem_u.last_wd, 32'h805c ^ MSK);
    chk("evict", rd, 32'ha048 ^ MSK);
    core(6'h00, 32'h3f8, 32'h3f8, 32'h0);
    core(6'h10, 32'h3fc, 32'h3fc, 32'h0);
    chk("seq", mem_u.last_seq, 1'b1);
    core(6'h10, 32'h400, 32'h400, 32'h0);
    chk("split", mem_u.last_seq, 1'b0);
    $display("done cache");
  endtask
  // a reset with a buffered write still queued must drop it
  task automatic t_rst();
    slow <= 5'h14;
    core(6'h05, 32'h700, 32'h700, 32'h1);
    core(6'h05, 32'h704, 32'h704, 32'h2);
    w0 = mem_u.n_wr;
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    slow <= 5'h0;
    @(posedge sys_clk);
    ahb(1'b0, 32'h8, 32'h0);
    chk("rstq", rd[18:0], 19'h1);
    ahb(1'b0, 32'h0, 32'h0);
    chk("rstc", rd, 32'h0);
    repeat (30) @(posedge sys_clk);
    chk("rstw", mem_u.n_wr - w0, 0);
    $display("done reset");
  endtask
  initial begin
    {rst_n, hsel, hwrite, core_req, core_write, core_swap, core_burst, err_on} = 8'h0;
    {core_ctt, core_btt, core_mmu_abort, htrans, slow} = 10'h0;
    {haddr, hwdata, core_vaddr, core_paddr, core_wdata} = 160'h0;
    err_total = 0;
    n_checks = 0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_regs();
    t_unc();
    t_cache();
    t_rst();
    end_sim();
  end
endmodule
`default_nettype wire
